// ### rtl/posc_pkg.sv
// constants, register map and types for the pwm output stage control block
package posc_pkg;

    // ************************************************************
    // register offsets (serial control subaddresses)
    // ************************************************************
    localparam logic [7:0] ADDR_VOL_RAMP   = 8'h0e;
    localparam logic [7:0] ADDR_MOD_LIMIT  = 8'h10;
    localparam logic [7:0] ADDR_DLY_ONE    = 8'h11;
    localparam logic [7:0] ADDR_DLY_TWO    = 8'h12;
    localparam logic [7:0] ADDR_DLY_ONE_N  = 8'h13;
    localparam logic [7:0] ADDR_DLY_TWO_N  = 8'h14;
    localparam logic [7:0] ADDR_STOP_GROUP = 8'h19;
    localparam logic [7:0] ADDR_SOFT_PER   = 8'h1a;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_VOL_RAMP   = 8'h00;
    localparam logic [7:0] RST_MOD_LIMIT  = 8'h00;
    localparam logic [7:0] RST_DLY_ONE    = 8'hac;
    localparam logic [7:0] RST_DLY_TWO    = 8'h54;
    localparam logic [7:0] RST_STOP_GROUP = 8'h30;
    localparam logic [7:0] RST_SOFT_PER   = 8'h0f;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int SLEW_LSB     = 0;
    localparam int SLEW_W       = 3;
    localparam int LIMIT_W      = 3;
    localparam int SKEW_LSB     = 2;
    localparam int SKEW_W       = 6;
    localparam int GROUP_W      = 4;
    localparam int SOFT_DIS_BIT = 7;
    localparam int SOFT_CODE_W  = 5;
    localparam int SKEW_UNIT    = 4;   // delay clocks per skew step

    // slew codes and step counts
    localparam logic [2:0]  SLEW_512   = 3'h0;
    localparam logic [2:0]  SLEW_1024  = 3'h1;
    localparam logic [2:0]  SLEW_2048  = 3'h2;
    localparam logic [2:0]  SLEW_256   = 3'h3;
    localparam logic [11:0] STEPS_256  = 12'h100;
    localparam logic [11:0] STEPS_512  = 12'h200;
    localparam logic [11:0] STEPS_1024 = 12'h400;
    localparam logic [11:0] STEPS_2048 = 12'h800;

    // ************************************************************
    // timing: ramp step time per rate family, in ns
    // ************************************************************
    localparam int CLK_NS       = 50;
    localparam int STEP_8K_NS   = 125000;
    localparam int STEP_441_NS  = 90700;
    localparam int STEP_48_NS   = 83300;
    localparam int STEP_8K_CYC  = STEP_8K_NS / CLK_NS;
    localparam int STEP_441_CYC = STEP_441_NS / CLK_NS;
    localparam int STEP_48_CYC  = STEP_48_NS / CLK_NS;

    // soft period: shortest code 01000 lasts 16.5 ms
    localparam int SOFT_MIN_US   = 16500;
    localparam int SOFT_MIN_CYC  = SOFT_MIN_US * 1000 / CLK_NS;
    localparam logic [4:0] SOFT_FIRST_CODE = 5'h08;
    // hold length per code from 01000 up, in tenths of a millisecond
    localparam int SOFT_TENTH_US = 100;
    localparam int SOFT_TENTHS [24] = '{
        165, 239, 314, 404, 539, 703, 942, 1257,
        1646, 2394, 3142, 4039, 5386, 7031, 9425, 12566,
        17281, 25136, 32991, 42417, 56556, 73837, 98973, 131964
    };

    // sample rate family
    typedef enum logic [1:0] {
        POSC_FAM_8K  = 2'h0,
        POSC_FAM_441 = 2'h1,
        POSC_FAM_48  = 2'h2
    } posc_family_t;

    // shutdown sequencer, gray along stop->soft->run->soft
    typedef enum logic [1:0] {
        POSC_ST_STOP  = 2'b00,
        POSC_ST_START = 2'b01,
        POSC_ST_RUN   = 2'b11,
        POSC_ST_HALT  = 2'b10
    } posc_state_t;

endpackage : posc_pkg

// ### rtl/posc_soft_timer.sv
// soft start/stop period timer for the pwm output stage
`timescale 1ns/100ps
module posc_soft_timer #(
    parameter int BASE_CYC = posc_pkg::SOFT_MIN_CYC
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // control
    input  wire logic       start_i,
    input  wire logic [4:0] code_i,
    // status
    output logic            busy_o
);
    // clocks per table unit; BASE_CYC is the length of the 16.5 ms hold
    localparam int TENTH_CYC = BASE_CYC * posc_pkg::SOFT_TENTH_US /
                               posc_pkg::SOFT_MIN_US;

    // the prescaler is 24 bits wide, so the unit must fit in it
    if (TENTH_CYC < 1 || TENTH_CYC > 32'hffffff) begin : g_bad_base
        $error("posc_soft_timer: BASE_CYC out of range");
    end

    logic [23:0] pre_ff;
    logic [23:0] nxt_pre;
    logic [16:0] units_ff;
    logic [16:0] nxt_units;
    logic [16:0] load_units;
    wire  [4:0]  idx = code_i - posc_pkg::SOFT_FIRST_CODE;

    // codes below 01000 give no hold; above, one table entry per code
    assign load_units = (code_i < posc_pkg::SOFT_FIRST_CODE) ? 17'h00000 :
        17'(posc_pkg::SOFT_TENTHS[idx]);

    // unit prescaler and unit countdown; a new start restarts the hold
    always_comb begin
        nxt_pre   = pre_ff;
        nxt_units = units_ff;
        if (start_i) begin
            nxt_pre   = 24'(TENTH_CYC - 1);
            nxt_units = load_units;
        end else if (units_ff != 17'h00000) begin
            if (pre_ff == 24'h000000) begin
                nxt_pre   = 24'(TENTH_CYC - 1);
                nxt_units = units_ff - 17'h00001;
            end else begin
                nxt_pre = pre_ff - 24'h000001;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pre_ff   <= 24'h000000;
            units_ff <= 17'h00000;
        end else begin
            pre_ff   <= nxt_pre;
            units_ff <= nxt_units;
        end
    end

    assign busy_o = (units_ff != 17'h00000);

endmodule : posc_soft_timer

// ### rtl/posc_ctrl.sv
// pwm output stage control: registers, ramp pacing, skews, shutdown sequence
// ************************************************************
// Summary of operation
// - slew field bits 2..0 sets ramp steps
// - ramp step paced by rate family
// - slew codes 512,1024,2048,256; top bit reserved
// - three-bit modulation limit code, upper bits zero
// - signed six-bit skew times four delay clocks
// - four skew registers, resets ac,54,ac,54
// - group members stay stopped unless group_bypass_i set
// - soft period after shutdown or power-down change
// - fifty percent hold period set by code
// - clearing all_stop_i exits shutdown while power_down_pin_i is low; set stops all channels after any soft hold
// ************************************************************
`timescale 1ns/100ps
module posc_ctrl (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // register access
    input  wire logic        wr_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    // system context
    input  wire logic        all_stop_i,
    input  wire logic        group_bypass_i,
    input  wire logic        power_down_pin_i,
    input  wire logic [1:0]  rate_family_i,
    input  wire logic        period_edge_i,
    input  wire logic        ramp_req_i,
    // modulator settings
    output logic      [11:0] ramp_steps_o,
    output logic             ramp_step_o,
    output logic      [2:0]  mod_limit_o,
    output logic      [31:0] skew_o,
    output logic      [3:0]  chan_run_o,
    output logic             half_duty_o
);
    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] vol_ff, lim_ff, grp_ff, soft_ff;
    logic [7:0] dly_ff [4];
    wire  hit_vol  = wr_en_i && addr_i == posc_pkg::ADDR_VOL_RAMP;
    wire  hit_lim  = wr_en_i && addr_i == posc_pkg::ADDR_MOD_LIMIT;
    wire  hit_grp  = wr_en_i && addr_i == posc_pkg::ADDR_STOP_GROUP;
    wire  hit_soft = wr_en_i && addr_i == posc_pkg::ADDR_SOFT_PER;

    // reserved bits are stored but ignored; keeps readback faithful
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            vol_ff  <= posc_pkg::RST_VOL_RAMP;
            lim_ff  <= posc_pkg::RST_MOD_LIMIT;
            grp_ff  <= posc_pkg::RST_STOP_GROUP;
            soft_ff <= posc_pkg::RST_SOFT_PER;
        end else begin
            if (hit_vol)  vol_ff  <= wdata_i;
            if (hit_lim)  lim_ff  <= wdata_i;
            if (hit_grp)  grp_ff  <= wdata_i;
            if (hit_soft) soft_ff <= wdata_i;
        end
    end

    // one generate entry per skew channel: 1, 2, 1 inverted, 2 inverted
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dly
            localparam logic [7:0] ADDR = 8'(posc_pkg::ADDR_DLY_ONE + gi);
            localparam logic [7:0] RST  = (gi % 2 == 0) ?
                posc_pkg::RST_DLY_ONE : posc_pkg::RST_DLY_TWO;
            logic [7:0] held_ff;
            wire  [5:0] code = dly_ff[gi][posc_pkg::SKEW_LSB +:
                                          posc_pkg::SKEW_W];
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    dly_ff[gi] <= RST;
                end else if (wr_en_i && addr_i == ADDR) begin
                    dly_ff[gi] <= wdata_i;
                end
            end
            // skew in delay clocks = signed code * 4, taken at boundary
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    held_ff <= 8'(signed'(RST[7:2]) * posc_pkg::SKEW_UNIT);
                end else if (period_edge_i) begin
                    held_ff <= {code, 2'b00};
                end
            end
            assign skew_o[gi*8 +: 8] = held_ff;
        end
    endgenerate

    // register readback, unmapped addresses read zero
    always_comb begin
        unique case (addr_i)
            posc_pkg::ADDR_VOL_RAMP:   rdata_o = vol_ff;
            posc_pkg::ADDR_MOD_LIMIT:  rdata_o = lim_ff;
            posc_pkg::ADDR_DLY_ONE:    rdata_o = dly_ff[0];
            posc_pkg::ADDR_DLY_TWO:    rdata_o = dly_ff[1];
            posc_pkg::ADDR_DLY_ONE_N:  rdata_o = dly_ff[2];
            posc_pkg::ADDR_DLY_TWO_N:  rdata_o = dly_ff[3];
            posc_pkg::ADDR_STOP_GROUP: rdata_o = grp_ff;
            posc_pkg::ADDR_SOFT_PER:   rdata_o = soft_ff;
            default:                   rdata_o = 8'h00;
        endcase
    end

    // ************************************************************
    // volume ramp pacing
    // ************************************************************
    wire [2:0] slew = vol_ff[posc_pkg::SLEW_LSB +: posc_pkg::SLEW_W];
    logic [11:0] steps;
    // reserved codes fall back to the default so a ramp never stalls
    always_comb begin
        unique case (slew)
            posc_pkg::SLEW_1024: steps = posc_pkg::STEPS_1024;
            posc_pkg::SLEW_2048: steps = posc_pkg::STEPS_2048;
            posc_pkg::SLEW_256:  steps = posc_pkg::STEPS_256;
            default:             steps = posc_pkg::STEPS_512;
        endcase
    end

    logic [12:0] step_reload;
    assign step_reload =
        (rate_family_i == posc_pkg::POSC_FAM_441) ?
            13'(posc_pkg::STEP_441_CYC - 1) :
        (rate_family_i == posc_pkg::POSC_FAM_48) ?
            13'(posc_pkg::STEP_48_CYC - 1) :
            13'(posc_pkg::STEP_8K_CYC - 1);

    logic [12:0] pace_ff;
    logic [11:0] left_ff;
    logic [11:0] steps_ff;
    wire  pace_done = (pace_ff == 13'h0000);
    wire  ramping   = (left_ff != 12'h000);

    // a new ramp request restarts the step count with the current slew
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pace_ff  <= 13'h0000;
            left_ff  <= 12'h000;
            steps_ff <= posc_pkg::STEPS_512;
        end else begin
            if (ramp_req_i) begin
                left_ff  <= steps;
                steps_ff <= steps;
                pace_ff  <= step_reload;
            end else if (ramping) begin
                pace_ff <= pace_done ? step_reload : pace_ff - 13'h0001;
                if (pace_done) left_ff <= left_ff - 12'h001;
            end
        end
    end
    assign ramp_steps_o = steps_ff;
    assign ramp_step_o  = ramping && pace_done && !ramp_req_i;

    // ************************************************************
    // modulation limit, taken at the period boundary
    // ************************************************************
    logic [2:0] lim_held_ff;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lim_held_ff <= posc_pkg::RST_MOD_LIMIT[2:0];
        end else if (period_edge_i) begin
            lim_held_ff <= lim_ff[posc_pkg::LIMIT_W-1:0];
        end
    end
    assign mod_limit_o = lim_held_ff;

    // ************************************************************
    // shutdown sequencer with soft start/stop
    // ************************************************************
    posc_pkg::posc_state_t state_ff, nxt_state;
    logic pdn_ff, stop_ff;
    wire  want_run  = !all_stop_i && !power_down_pin_i;
    wire  cmd_edge  = (all_stop_i != stop_ff) ||
                      (power_down_pin_i != pdn_ff);
    wire  soft_on   = !soft_ff[posc_pkg::SOFT_DIS_BIT];
    wire  soft_kick = cmd_edge && soft_on;
    logic soft_busy;

    posc_soft_timer u_soft (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .start_i (soft_kick),
        .code_i  (soft_ff[posc_pkg::SOFT_CODE_W-1:0]),
        .busy_o  (soft_busy)
    );
    // a disabled timer never holds, even if it was still counting
    wire  soft_hold = soft_busy && soft_on;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            posc_pkg::POSC_ST_STOP:
                if (want_run) nxt_state = posc_pkg::POSC_ST_START;
            posc_pkg::POSC_ST_START:
                if (!want_run) nxt_state = posc_pkg::POSC_ST_HALT;
                else if (!soft_hold && !soft_kick)
                    nxt_state = posc_pkg::POSC_ST_RUN;
            posc_pkg::POSC_ST_RUN:
                if (!want_run) nxt_state = posc_pkg::POSC_ST_HALT;
            posc_pkg::POSC_ST_HALT:
                if (!soft_hold && !soft_kick)
                    nxt_state = posc_pkg::POSC_ST_STOP;
        endcase
    end

    logic [3:0] run_ff;
    // membership mask counts only when the bypass bit is clear
    wire  [3:0] members = group_bypass_i ? 4'h0 :
                          grp_ff[posc_pkg::GROUP_W-1:0];

    // outputs change only on a pwm period boundary
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_ff    <= posc_pkg::POSC_ST_STOP;
            pdn_ff      <= 1'b0;    // pin idle level: no false kick
            stop_ff     <= 1'b1;
            run_ff      <= 4'h0;
            half_duty_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pdn_ff   <= power_down_pin_i;
            stop_ff  <= all_stop_i;
            if (period_edge_i) begin
                run_ff <= (state_ff == posc_pkg::POSC_ST_STOP) ? 4'h0 :
                          ~members;
                half_duty_o <= soft_hold &&
                    ((state_ff == posc_pkg::POSC_ST_START) ||
                     (state_ff == posc_pkg::POSC_ST_HALT));
            end
        end
    end
    assign chan_run_o = run_ff;

endmodule : posc_ctrl

// ### dv/posc_ctrl_monitor.sv
// concurrent checks on the pwm output stage control ports
`timescale 1ns/100ps
module posc_ctrl_monitor (
    // clock, reset and register access
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        wr_en_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  rdata_o,
    // context and settings
    input wire logic        period_edge_i,
    input wire logic        group_bypass_i,
    input wire logic [1:0]  rate_family_i,
    input wire logic        ramp_req_i,
    input wire logic [11:0] ramp_steps_o,
    input wire logic        ramp_step_o,
    input wire logic [2:0]  mod_limit_o,
    input wire logic [31:0] skew_o,
    input wire logic [3:0]  chan_run_o
);
    // ****************
    // helper logic
    // ****************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [11:0] gap_ff;
    logic        seen_ff;
    logic [1:0]  fam_ff;
    logic [11:0] pace;
    logic [11:0] exp_steps;
    // pace is only judged between two steps of one ramp at one rate
    assign pace = (rate_family_i == 2'h1) ? 12'(posc_pkg::STEP_441_CYC)
                : (rate_family_i == 2'h2) ? 12'(posc_pkg::STEP_48_CYC)
                : 12'(posc_pkg::STEP_8K_CYC);
    assign exp_steps = rdata_o[2] ? posc_pkg::STEPS_512
                     : (rdata_o[1:0] == 2'h1) ? posc_pkg::STEPS_1024
                     : (rdata_o[1:0] == 2'h2) ? posc_pkg::STEPS_2048
                     : (rdata_o[1:0] == 2'h3) ? posc_pkg::STEPS_256
                     : posc_pkg::STEPS_512;
    // cycles since the last ramp step
    always_ff @(posedge clock_i) begin
        fam_ff <= rate_family_i;
        gap_ff <= ramp_step_o ? 12'h001 : gap_ff + 12'h001;
        if (!rst_n_i || ramp_req_i || rate_family_i != fam_ff)
            seen_ff <= 1'b0;
        else if (ramp_step_o)
            seen_ff <= 1'b1;
    end
    sequence s_step_again;
        ramp_step_o && seen_ff;
    endsequence
    sequence s_ramp_load;
        ramp_req_i && addr_i == posc_pkg::ADDR_VOL_RAMP && !wr_en_i;
    endsequence
    chk_ramp_pace: assert property (s_step_again |-> gap_ff == pace)
        else $error("ramp step spacing off");
    chk_steps_take: assert property (s_ramp_load |=>
        ramp_steps_o == $past(exp_steps))
        else $error("ramp step count not decoded");
    chk_limit_hold: assert property (!period_edge_i |=>
        $stable(mod_limit_o)) else $error("limit moved off boundary");
    chk_skew_hold: assert property (!period_edge_i |=>
        $stable(skew_o)) else $error("skew moved off boundary");
    chk_run_hold: assert property (!period_edge_i |=>
        $stable(chan_run_o)) else $error("run moved off boundary");
    chk_limit_take: assert property (period_edge_i && !wr_en_i &&
        addr_i == posc_pkg::ADDR_MOD_LIMIT |=>
        mod_limit_o == $past(rdata_o[2:0])) else $error("limit not taken");
    chk_skew_take: assert property (period_edge_i && !wr_en_i &&
        addr_i == posc_pkg::ADDR_DLY_TWO_N |=>
        skew_o[31:24] == ($past(rdata_o) & 8'hfc)) else $error("bad skew");
    chk_group_mask: assert property (period_edge_i && !wr_en_i &&
        !group_bypass_i && addr_i == posc_pkg::ADDR_STOP_GROUP |=>
        (chan_run_o & $past(rdata_o[3:0])) == 4'h0)
        else $error("group member running");
endmodule : posc_ctrl_monitor

// ### dv/posc_host_model.sv
// host model: register writes and read addresses toward the block
`timescale 1ns/100ps
module posc_host_model (
    // clock
    input  wire logic       clock_i,
    // register access
    output logic            wr_en_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end
    // one-cycle strobe; data inverted after so stale data never matches
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_en_o <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clock_i);
        wr_en_o <= 1'b0;
        wdata_o <= ~d;
    endtask : put
    task automatic point(input logic [7:0] a);
        @(posedge clock_i);
        addr_o <= a;
    endtask : point
    // skews for three-level modulation, loaded before shutdown exit
    task automatic load_three_level();
        put(posc_pkg::ADDR_DLY_ONE, 8'hb8);
        put(posc_pkg::ADDR_DLY_TWO, 8'h60);
        put(posc_pkg::ADDR_DLY_ONE_N, 8'ha0);
        put(posc_pkg::ADDR_DLY_TWO_N, 8'h48);
    endtask : load_three_level
    task automatic set_group(input logic parallel);
        put(posc_pkg::ADDR_STOP_GROUP, parallel ? 8'h3a : 8'h30);
    endtask : set_group
endmodule : posc_host_model

// ### dv/tb.sv
// self-checking bench for the pwm output stage control block
`timescale 1ns/100ps
module tb;
    logic        clock_i, rst_n_i, all_stop_i, group_bypass_i;
    logic        power_down_pin_i, period_edge_i, ramp_req_i;
    logic        pe_run, hd_seen, ramp_step_o, half_duty_o;
    logic [1:0]  rate_family_i;
    logic [3:0]  pcnt, chan_run_o;
    logic [2:0]  mod_limit_o;
    logic [7:0]  rdata_o;
    logic [11:0] ramp_steps_o;
    logic [31:0] skew_o, seed, old;
    wire logic   wr_en_i;
    wire logic [7:0] addr_i, wdata_i;
    int          fails, num_checks, n;
    logic [7:0]  ra [9] = '{8'h0e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                            8'h19, 8'h1a, 8'h0f};
    logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'hac, 8'h54, 8'hac, 8'h54,
                            8'h30, 8'h0f, 8'h00};
    logic [7:0]  rm [9] = '{8'h07, 8'h07, 8'hfc, 8'hfc, 8'hfc, 8'hfc,
                            8'h0f, 8'h9f, 8'hff};
    posc_ctrl posc_ctrl_i (.clock_i, .rst_n_i, .wr_en_i, .addr_i,
        .wdata_i, .rdata_o, .all_stop_i, .group_bypass_i,
        .power_down_pin_i, .rate_family_i, .period_edge_i, .ramp_req_i,
        .ramp_steps_o, .ramp_step_o, .mod_limit_o, .skew_o, .chan_run_o,
        .half_duty_o);
    posc_host_model host_i (.clock_i, .wr_en_o(wr_en_i), .addr_o(addr_i),
        .wdata_o(wdata_i));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [11:0] steps(input logic [2:0] c);
        if (c[2]) return 12'd512;
        return (c == 3'h1) ? 12'd1024 : (c == 3'h2) ? 12'd2048
             : (c == 3'h3) ? 12'd256 : 12'd512;
    endfunction : steps
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic ramp(input logic [1:0] f);
        @(posedge clock_i);
        rate_family_i <= f;
        ramp_req_i    <= 1'b1;
        @(posedge clock_i);
        ramp_req_i <= 1'b0;
    endtask : ramp
    // spacing of the first two steps of a fresh ramp
    task automatic pace(input logic [1:0] f, input int exp);
        ramp(f);
        for (n = 0; n < 6000 && ramp_step_o !== 1'b1; n++)
            @(negedge clock_i);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (ramp_step_o !== 1'b1 && n < 6000);
        check(n, exp);
    endtask : pace
    // clock, period boundaries and the half-duty watcher
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        pcnt          <= pcnt + 4'h1;
        period_edge_i <= pe_run && pcnt == 4'hf;
    end
    always @(negedge clock_i)
        if (half_duty_o === 1'b1) hd_seen <= 1'b1;
    initial begin
        repeat (60000) @(posedge clock_i);
        fails++;
        complete_run();
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        {rst_n_i, ramp_req_i, period_edge_i, group_bypass_i} = '0;
        {power_down_pin_i, hd_seen, pcnt, rate_family_i} = '0;
        {all_stop_i, pe_run} = 2'b11;
        seed = 32'h223c;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(negedge clock_i);
        check({mod_limit_o, chan_run_o, half_duty_o}, 0);
        check(skew_o, 32'h54ac54ac);
        for (int i = 0; i < 9; i++) begin
            host_i.point(ra[i]);
            @(negedge clock_i);
            check(rdata_o, rv[i]);
        end
        for (int i = 0; i < 9; i++) begin
            seed = xs(seed);
            host_i.put(ra[i], seed[7:0]);
            host_i.point(ra[i]);
            @(negedge clock_i);
            check(rdata_o & rm[i], (i == 8) ? 0 : seed[7:0] & rm[i]);
        end
        for (int c = 0; c < 8; c++) begin
            host_i.put(posc_pkg::ADDR_VOL_RAMP, 8'(c));
            ramp(2'h2);
            @(negedge clock_i);
            check(ramp_steps_o, steps(3'(c)));
        end
        pace(2'h0, 125000 / 50);
        pace(2'h1, 90700 / 50);
        pace(2'h2, 83300 / 50);
        // settings wait for a period boundary
        pe_run <= 1'b0;
        host_i.put(posc_pkg::ADDR_SOFT_PER, 8'h80);
        old = skew_o;
        host_i.load_three_level();
        repeat (20) @(posedge clock_i);
        check(skew_o, old);
        pe_run <= 1'b1;
        repeat (40) @(posedge clock_i);
        check(skew_o, 32'h48a060b8);
        host_i.put(posc_pkg::ADDR_MOD_LIMIT, 8'h07);
        repeat (40) @(posedge clock_i);
        check(mod_limit_o, 3'h7);
        // shutdown exit with the group, then bypass, then hard mute
        host_i.set_group(1'b1);
        hd_seen = 1'b0;
        all_stop_i <= 1'b0;
        for (n = 0; n < 400 && chan_run_o === 4'h0; n++)
            @(negedge clock_i);
        repeat (40) @(negedge clock_i);
        check(chan_run_o, 4'b0101);
        @(posedge clock_i);
        group_bypass_i <= 1'b1;
        repeat (40) @(negedge clock_i);
        check(chan_run_o, 4'hf);
        // stop entry with the timer on but a code that gives no hold
        host_i.put(posc_pkg::ADDR_SOFT_PER, 8'h03);
        all_stop_i <= 1'b1;
        for (n = 0; n < 400 && chan_run_o !== 4'h0; n++)
            @(negedge clock_i);
        check(chan_run_o, 4'h0);
        check(hd_seen, 1'b0);
        // power-down held across the shutdown exit keeps channels stopped
        host_i.put(posc_pkg::ADDR_SOFT_PER, 8'h08);
        power_down_pin_i <= 1'b1;
        all_stop_i <= 1'b0;
        repeat (40) @(negedge clock_i);
        check(chan_run_o, 4'h0);
        check(half_duty_o, 1'b0);
        @(posedge clock_i);
        power_down_pin_i <= 1'b0;
        for (n = 0; n < 400 && half_duty_o !== 1'b1; n++)
            @(negedge clock_i);
        check(half_duty_o, 1'b1);
        complete_run();
    end
endmodule : tb
bind posc_ctrl posc_ctrl_monitor posc_ctrl_monitor_i (.clock_i, .rst_n_i,
    .wr_en_i, .addr_i, .rdata_o, .period_edge_i, .group_bypass_i,
    .rate_family_i, .ramp_req_i, .ramp_steps_o, .ramp_step_o,
    .mod_limit_o, .skew_o, .chan_run_o);
